// File: pkg/atb_pkg.sv
// Constants for the analog trim register bank.
// Assumes a single 20 MHz register clock and an active-low reset.
package atb_pkg;

    // ****************************************************************
    // Register window bases and offsets
    // ****************************************************************
    // Global base for a blocking access.
    localparam logic [15:0] ATB_BASE_BLOCKING    = 16'h0200;
    // Global base for a non-blocking access.
    localparam logic [15:0] ATB_BASE_NONBLOCKING = 16'h0300;
    // Offset of the sleep reference trim register.
    localparam logic [7:0]  ATB_OFS_SLEEP        = 8'hF2;
    // Offset of the ADC offset trim register.
    localparam logic [7:0]  ATB_OFS_ADC          = 8'hF3;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    // Sleep reference trim enable bit.
    localparam int ATB_SLP_EN_BIT    = 4;
    // Sleep reference trim lock bit.
    localparam int ATB_SLP_LOCK_BIT  = 3;
    // Sleep reference code sits in bits 2 to 0.
    localparam int ATB_SLP_CODE_MSB  = 2;
    localparam int ATB_SLP_CODE_LSB  = 0;
    // ADC offset trim enable bit.
    localparam int ATB_ADC_EN_BIT    = 7;
    // ADC offset code sits in bits 6 to 4.
    localparam int ATB_ADC_CODE_MSB  = 6;
    localparam int ATB_ADC_CODE_LSB  = 4;
    // Spare enable bit, spare bits in 2 to 0.
    localparam int ATB_SPARE_EN_BIT  = 3;
    localparam int ATB_SPARE_MSB     = 2;
    localparam int ATB_SPARE_LSB     = 0;

    // ****************************************************************
    // Reset values and masks
    // ****************************************************************
    // Both registers clear to zero.
    localparam logic [7:0] ATB_RESET_VALUE   = 8'h00;
    // Writable bits of the sleep register; bits 7 to 5 stay zero.
    localparam logic [7:0] ATB_SLP_WR_MASK   = 8'h1F;
    // Code sent to the analog side while a trim is disabled.
    localparam logic [2:0] ATB_DEFAULT_CODE  = 3'h0;
    // Read data for an unmapped address.
    localparam logic [7:0] ATB_UNMAPPED_DATA = 8'h00;
    // Sleep step count after reset: the default lowest setting.
    localparam logic signed [2:0] ATB_SLP_STEP_RESET = 3'sh5;
    // ADC step count after reset: zero adjustment.
    localparam logic signed [2:0] ATB_ADC_STEP_RESET = 3'sh0;

endpackage

// File: src/atb_trim_decode.sv
// Decoder of the two 3-bit trim codes into signed step counts.
// Assumes codes already forced to default while their trim is disabled.
`timescale 1ns/1ps

module atb_trim_decode
    import atb_pkg::*;
(
    input  wire logic              [2:0] sleep_code_i, // Sleep code.
    input  wire logic              [2:0] adc_code_i,   // ADC offset code.
    output logic signed            [2:0] sleep_step_o, // Sleep steps.
    output logic signed            [2:0] adc_step_o    // ADC steps.
);

    // ****************************************************************
    // Decode functions
    // ****************************************************************

    // Sleep code: seven steps, both end codes give the lowest setting.
    function automatic logic signed [2:0] sleep_steps(
        input logic [2:0] code
    );
        logic signed [2:0] s;
        s = -3'sd3;
        case (code)
            3'h1: s = -3'sd2;
            3'h2: s = -3'sd1;
            3'h3: s = 3'sd0;
            3'h4: s = 3'sd1;
            3'h5: s = 3'sd2;
            3'h6: s = 3'sd3;
            default: s = -3'sd3;
        endcase
        return s;
    endfunction

    // ADC code: both end codes give zero, low half up, high half down.
    function automatic logic signed [2:0] adc_steps(
        input logic [2:0] code
    );
        logic signed [2:0] s;
        s = 3'sd0;
        case (code)
            3'h1: s = 3'sd1;
            3'h2: s = 3'sd2;
            3'h3: s = 3'sd3;
            3'h4: s = -3'sd3;
            3'h5: s = -3'sd2;
            3'h6: s = -3'sd1;
            default: s = 3'sd0;
        endcase
        return s;
    endfunction

    // Apply both decoders.
    always_comb begin
        sleep_step_o = sleep_steps(sleep_code_i);
        adc_step_o   = adc_steps(adc_code_i);
    end

endmodule

// File: src/atb_trim_bank.sv
// Analog trim register bank: sleep reference trim and ADC offset trim.
// Assumes register accesses from logic on clk_i, one per cycle.
//
// Overview of operation
// - Sleep trim applies only while enabled
// - Sleep lock flag stored at bit 3
// - Sleep code: 000/111 lowest, 011 zero
// - Registers at base 0x0200 or 0x300
// - ADC offset code ignored unless bit 7
// - ADC code signed: 1-3 up, 4-6 down
// - Spare enable and spare bits read/write
// - Sleep register at 0xF2, top bits zero
`timescale 1ns/1ps

module atb_trim_bank
    import atb_pkg::*;
(
    input  wire logic               clk_i,                    // Clock.
    input  wire logic               resetn_i,                 // Reset.
    input  wire logic        [15:0] reg_addr_i,               // Address.
    input  wire logic               reg_wr_i,                 // Write.
    input  wire logic               reg_rd_i,                 // Read.
    input  wire logic         [7:0] reg_wdata_i,              // Wr data.
    output logic              [7:0] reg_rdata_o,              // Rd data.
    output logic                    reg_ack_o,                // Done.
    output logic                    sleep_ref_trim_enable_o,  // Enable.
    output logic                    sleep_ref_trim_lock_o,    // Lock.
    output logic              [2:0] sleep_ref_trim_code_o,    // Code.
    output logic signed       [2:0] sleep_ref_step_o,         // Steps.
    output logic                    adc_offset_trim_enable_o, // Enable.
    output logic              [2:0] adc_offset_trim_code_o,   // Code.
    output logic signed       [2:0] adc_offset_step_o,        // Steps.
    output logic                    spare_trim_enable_o,      // Spare.
    output logic              [2:0] spare_trim_bits_o         // Spares.
);

    // ****************************************************************
    // Address decode
    // ****************************************************************

    // True when the address hits an offset through either base.
    function automatic logic hits(
        input logic [15:0] addr,
        input logic [7:0]  ofs
    );
        return (addr == ATB_BASE_BLOCKING + {8'h00, ofs}) ||
               (addr == ATB_BASE_NONBLOCKING + {8'h00, ofs});
    endfunction

    logic hit_sleep; // Access aims at the sleep register.
    logic hit_adc;   // Access aims at the ADC offset register.

    // Both bases reach the same storage.
    always_comb begin
        hit_sleep = hits(reg_addr_i, ATB_OFS_SLEEP);
        hit_adc   = hits(reg_addr_i, ATB_OFS_ADC);
    end

    // ****************************************************************
    // Register storage and bus answer
    // ****************************************************************

    logic [7:0] sleep_reg;       // Stored sleep trim register.
    logic [7:0] adc_reg;         // Stored ADC offset trim register.
    logic [7:0] next_sleep_reg;  // Next sleep register value.
    logic [7:0] next_adc_reg;    // Next ADC register value.
    logic [7:0] next_rdata;      // Next read data.
    logic       next_ack;        // Next acknowledge.

    // Writes land on the next edge; reads return the old value.
    always_comb begin
        next_sleep_reg = sleep_reg;
        next_adc_reg   = adc_reg;
        next_ack       = reg_wr_i | reg_rd_i;
        next_rdata     = ATB_UNMAPPED_DATA;
        if (reg_wr_i && hit_sleep) begin
            next_sleep_reg = reg_wdata_i & ATB_SLP_WR_MASK;
        end
        if (reg_wr_i && hit_adc) begin
            next_adc_reg = reg_wdata_i;
        end
        if (reg_rd_i && hit_sleep) begin
            // Read back of the sleep register.
            next_rdata = sleep_reg;
        end else if (reg_rd_i && hit_adc) begin
            // Read back of the ADC offset register.
            next_rdata = adc_reg;
        end else begin
            // Unmapped or idle cycles read as zero.
            next_rdata = ATB_UNMAPPED_DATA;
        end
    end

    // Register the storage and the answer; reset clears everything.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sleep_reg   <= ATB_RESET_VALUE;
            adc_reg     <= ATB_RESET_VALUE;
            reg_rdata_o <= ATB_UNMAPPED_DATA;
            reg_ack_o   <= 1'b0;
        end else begin
            sleep_reg   <= next_sleep_reg;
            adc_reg     <= next_adc_reg;
            reg_rdata_o <= next_rdata;
            reg_ack_o   <= next_ack;
        end
    end

    // ****************************************************************
    // Applied trim settings
    // ****************************************************************

    logic              next_slp_en;    // Next sleep enable.
    logic              next_slp_lock;  // Next applied lock.
    logic        [2:0] next_slp_code;  // Next applied sleep code.
    logic              next_adc_en;    // Next ADC enable.
    logic        [2:0] next_adc_code;  // Next applied ADC code.
    logic signed [2:0] next_slp_step;  // Decoded sleep steps.
    logic signed [2:0] next_adc_step;  // Decoded ADC steps.

    // Gate each code by its enable from the next stored value, so the
    // applied setting moves on the same edge as the register.
    always_comb begin
        next_slp_en   = next_sleep_reg[ATB_SLP_EN_BIT];
        next_adc_en   = next_adc_reg[ATB_ADC_EN_BIT];
        next_slp_lock = 1'b0;
        next_slp_code = ATB_DEFAULT_CODE;
        next_adc_code = ATB_DEFAULT_CODE;
        if (next_slp_en) begin
            next_slp_lock = next_sleep_reg[ATB_SLP_LOCK_BIT];
            next_slp_code =
                next_sleep_reg[ATB_SLP_CODE_MSB:ATB_SLP_CODE_LSB];
        end else begin
            next_slp_code = ATB_DEFAULT_CODE;
        end
        if (next_adc_en) begin
            next_adc_code =
                next_adc_reg[ATB_ADC_CODE_MSB:ATB_ADC_CODE_LSB];
        end else begin
            next_adc_code = ATB_DEFAULT_CODE;
        end
    end

    // Step decoder for both codes.
    atb_trim_decode u_decode (
        .sleep_code_i (next_slp_code),
        .adc_code_i   (next_adc_code),
        .sleep_step_o (next_slp_step),
        .adc_step_o   (next_adc_step)
    );

    // Register the applied settings so the analog side sees flops.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sleep_ref_trim_enable_o  <= 1'b0;
            sleep_ref_trim_lock_o    <= 1'b0;
            sleep_ref_trim_code_o    <= ATB_DEFAULT_CODE;
            sleep_ref_step_o         <= ATB_SLP_STEP_RESET;
            adc_offset_trim_enable_o <= 1'b0;
            adc_offset_trim_code_o   <= ATB_DEFAULT_CODE;
            adc_offset_step_o        <= ATB_ADC_STEP_RESET;
            spare_trim_enable_o      <= 1'b0;
            spare_trim_bits_o        <= 3'h0;
        end else begin
            sleep_ref_trim_enable_o  <= next_slp_en;
            sleep_ref_trim_lock_o    <= next_slp_lock;
            sleep_ref_trim_code_o    <= next_slp_code;
            sleep_ref_step_o         <= next_slp_step;
            adc_offset_trim_enable_o <= next_adc_en;
            adc_offset_trim_code_o   <= next_adc_code;
            adc_offset_step_o        <= next_adc_step;
            spare_trim_enable_o      <= next_adc_reg[ATB_SPARE_EN_BIT];
            spare_trim_bits_o        <=
                next_adc_reg[ATB_SPARE_MSB:ATB_SPARE_LSB];
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // Sleep write stores only the low five bits.
    a_sleep_write_store: assert property (
        reg_wr_i && hits(reg_addr_i, ATB_OFS_SLEEP) |=>
        sleep_reg == ($past(reg_wdata_i) & ATB_SLP_WR_MASK))
        else $error("sleep register write mismatch");

    // Top bits of the sleep register never set.
    a_sleep_top_zero: assert property (
        reg_ack_o && $past(reg_rd_i) && $past(hit_sleep) |->
        reg_rdata_o[7:5] == 3'h0)
        else $error("sleep register top bits not zero");

    // Lock follows the stored bit while enabled.
    a_sleep_lock_applied: assert property (
        sleep_reg[ATB_SLP_EN_BIT] |->
        sleep_ref_trim_lock_o == sleep_reg[ATB_SLP_LOCK_BIT])
        else $error("sleep lock not applied");

    // Disabled sleep trim drives default and no lock.
    a_sleep_off_default: assert property (
        !sleep_ref_trim_enable_o |->
        sleep_ref_trim_code_o == ATB_DEFAULT_CODE &&
        !sleep_ref_trim_lock_o && sleep_ref_step_o == -3'sd3)
        else $error("disabled sleep trim not default");

    // Middle sleep code gives zero adjustment.
    a_sleep_step_mid: assert property (
        sleep_ref_trim_enable_o && sleep_ref_trim_code_o == 3'h3 |->
        sleep_ref_step_o == 3'sd0)
        else $error("sleep code 011 not zero");

    // Code 111 selects the same lowest setting as 000.
    a_sleep_step_low: assert property (
        sleep_ref_trim_code_o == 3'h7 |-> sleep_ref_step_o == -3'sd3)
        else $error("sleep code 111 not lowest");

    // Disabled ADC trim drives the default code, whatever is stored.
    a_adc_off_default: assert property (
        !adc_reg[ATB_ADC_EN_BIT] |->
        adc_offset_trim_code_o == ATB_DEFAULT_CODE &&
        adc_offset_step_o == 3'sd0)
        else $error("disabled ADC trim not default");

    // Enabled low ADC codes 001 to 011 raise the offset.
    a_adc_step_sign: assert property (
        adc_offset_trim_enable_o &&
        adc_offset_trim_code_o inside {3'h1, 3'h2, 3'h3} |->
        adc_offset_step_o > 3'sd0)
        else $error("ADC raise code not positive");

    // Spare bits follow a write to the ADC register.
    a_spare_write: assert property (
        reg_wr_i && hits(reg_addr_i, ATB_OFS_ADC) |=>
        adc_reg == $past(reg_wdata_i) &&
        {spare_trim_enable_o, spare_trim_bits_o} == adc_reg[3:0])
        else $error("spare bits not stored");

    // Unmapped reads answer next cycle with zero data.
    a_read_answer: assert property (
        reg_rd_i && !reg_wr_i && !hit_sleep && !hit_adc |=>
        reg_ack_o && reg_rdata_o == ATB_UNMAPPED_DATA)
        else $error("unmapped read answer wrong");

    // Scenarios worth seeing.
    c_nonblock_write: cover property (
        reg_wr_i && reg_addr_i == ATB_BASE_NONBLOCKING + 16'h00F3);
    c_sleep_enabled: cover property (
        sleep_ref_trim_enable_o && sleep_ref_trim_lock_o);
    c_adc_lower: cover property (
        adc_offset_trim_enable_o && adc_offset_step_o < 3'sd0);

endmodule

// File: tb/tb_top.sv
// Self-checking testbench for the analog trim register bank.
// Assumes the bank answers every access with a one-cycle ack.
`timescale 1ns/1ps

module tb_top
    import atb_pkg::*;
;
    // ****************************************************************
    // Signals, reference model and scoreboard
    // ****************************************************************
    logic        clk_i       = 1'b0;   // Register clock.
    logic        resetn_i    = 1'b0;   // Active-low reset.
    logic [15:0] reg_addr_i  = 16'h0000; // Access address.
    logic        reg_wr_i    = 1'b0;   // Write strobe.
    logic        reg_rd_i    = 1'b0;   // Read strobe.
    logic [7:0]  reg_wdata_i = 8'h00;  // Write data.
    logic [7:0]  reg_rdata_o;          // Read data.
    logic        reg_ack_o;            // Access done.
    logic        s_en, s_lock, a_en, sp_en; // Enables from the bank.
    logic [2:0]  s_code, a_code, sp_bits;   // Codes from the bank.
    logic [2:0]  s_step, a_step;            // Steps from the bank.
    logic [7:0]  sleep_m;              // Model of the sleep register.
    logic [7:0]  adc_m;                // Model of the ADC register.
    logic [7:0]  exp_q[$];             // Expected read data per ack.
    int          num_errors  = 0;      // Mismatch count.
    int          comparisons = 0;      // Comparison count.

    // The clock toggles every half period of 25 ns.
    always #25 clk_i = ~clk_i;

    atb_trim_bank dut (
        .clk_i                    (clk_i),
        .resetn_i                 (resetn_i),
        .reg_addr_i               (reg_addr_i),
        .reg_wr_i                 (reg_wr_i),
        .reg_rd_i                 (reg_rd_i),
        .reg_wdata_i              (reg_wdata_i),
        .reg_rdata_o              (reg_rdata_o),
        .reg_ack_o                (reg_ack_o),
        .sleep_ref_trim_enable_o  (s_en),
        .sleep_ref_trim_lock_o    (s_lock),
        .sleep_ref_trim_code_o    (s_code),
        .sleep_ref_step_o         (s_step),
        .adc_offset_trim_enable_o (a_en),
        .adc_offset_trim_code_o   (a_code),
        .adc_offset_step_o        (a_step),
        .spare_trim_enable_o      (sp_en),
        .spare_trim_bits_o        (sp_bits)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Prints one mismatch line and counts it.
    task automatic fail(input string msg);
        num_errors++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask

    // Compares one read result.
    task automatic cmp_rd(input logic [7:0] exp);
        comparisons++;
        if (reg_rdata_o !== exp) fail("read data");
    endtask

    // Checks the ack in the cycle after the edge: high only for a request.
    task automatic cmp_ack(input logic exp);
        comparisons++;
        if (reg_ack_o !== exp) fail("ack wrong");
    endtask

    // Sleep step: 000 and 111 lowest, 011 zero, rising to 110.
    function automatic logic [2:0] sstep(input logic [2:0] c);
        logic [2:0] tbl [8] = '{3'h5, 3'h6, 3'h7, 3'h0,
                                3'h1, 3'h2, 3'h3, 3'h5};
        return tbl[c];
    endfunction

    // ADC step: 000 and 111 zero, 001..011 up, 100..110 down.
    function automatic logic [2:0] astep(input logic [2:0] c);
        logic [2:0] tbl [8] = '{3'h0, 3'h1, 3'h2, 3'h3,
                                3'h5, 3'h6, 3'h7, 3'h0};
        return tbl[c];
    endfunction

    // Compares every trim output with the model.
    task automatic cmp_out();
        logic [2:0] sc;
        logic [2:0] ac;
        sc = sleep_m[4] ? sleep_m[2:0] : 3'h0;
        ac = adc_m[7] ? adc_m[6:4] : 3'h0;
        comparisons++;
        if ({s_en, s_lock, s_code, s_step, a_en, a_code, a_step, sp_en,
             sp_bits} !== {sleep_m[4], sleep_m[4] & sleep_m[3], sc,
             sstep(sc), adc_m[7], ac, astep(ac), adc_m[3], adc_m[2:0]})
            fail("trim outputs");
    endtask

    // One access: drives it, notes the answer, waits for the edge.
    task automatic acc(input logic [15:0] a, input logic w,
                       input logic r, input logic [7:0] d);
        logic hit;
        hit = (a[15:8] == ATB_BASE_BLOCKING[15:8] ||
               a[15:8] == ATB_BASE_NONBLOCKING[15:8]) &&
              (a[7:0] == ATB_OFS_SLEEP || a[7:0] == ATB_OFS_ADC);
        reg_addr_i  = a;
        reg_wr_i    = w;
        reg_rd_i    = r;
        reg_wdata_i = d;
        // A cycle with neither strobe is no access and gets no answer.
        if (w || r)
            exp_q.push_back((r && hit) ?
                ((a[7:0] == ATB_OFS_SLEEP) ? sleep_m : adc_m) : 8'h00);
        if (w && hit && a[7:0] == ATB_OFS_SLEEP) sleep_m = d & 8'h1F;
        if (w && hit && a[7:0] == ATB_OFS_ADC) adc_m = d;
        @(posedge clk_i);
        #2;
        cmp_ack(w | r);
        cmp_out();
    endtask

    // Releases the strobes for one cycle.
    task automatic idle();
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        @(posedge clk_i);
        #2;
    endtask

    // Applies reset for the given cycles and clears the model.
    task automatic do_reset(input int n);
        resetn_i = 1'b0;
        sleep_m  = 8'h00;
        adc_m    = 8'h00;
        repeat (n) @(posedge clk_i);
        #2;
        resetn_i = 1'b1;
        @(posedge clk_i);
        #2;
        cmp_out();
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Output watcher
    // ****************************************************************
    // Takes the oldest note whenever an ack appears.
    always @(negedge clk_i) begin
        if (reg_ack_o === 1'b1) begin
            if (exp_q.size() == 0) fail("ack without access");
            else cmp_rd(exp_q.pop_front());
        end
    end

    // ****************************************************************
    // Stimulus
    // ****************************************************************
    initial begin
        logic [15:0] amap [6] = '{16'h02F2, 16'h03F2, 16'h02F3,
                                  16'h03F3, 16'h02F0, 16'h04F2};
        void'($urandom(32'hCFC81827));
        do_reset(4);
        // Reset values read as zero at both bases.
        for (int i = 0; i < 4; i++) acc(amap[i], 1'b0, 1'b1, 8'h00);
        // Sleep: all codes, lock and enable, junk in bits 7 to 5.
        for (int i = 0; i < 32; i++)
            acc(amap[i % 2], 1'b1, 1'b1,
                {3'($urandom), 5'(i)});
        // ADC: every byte, read and write in one cycle.
        for (int i = 0; i < 256; i++)
            acc(amap[2 + i % 2], 1'b1, 1'b1, 8'(i));
        // Unmapped places read zero and ignore writes.
        acc(amap[4], 1'b1, 1'b1, 8'hA5);
        acc(amap[5], 1'b1, 1'b1, 8'h5A);
        // Random back-to-back traffic.
        for (int i = 0; i < 80; i++)
            acc(amap[$urandom % 6], 1'($urandom), 1'($urandom),
                8'($urandom));
        idle();
        repeat (3) idle();
        // Mid-run reset clears both registers.
        do_reset(2);
        acc(amap[1], 1'b0, 1'b1, 8'h00);
        acc(amap[2], 1'b0, 1'b1, 8'h00);
        // Startup copy of the factory trims into offsets F0 to F3, in order.
        for (int i = 0; i < 4; i++)
            acc(16'h02F0 + 16'(i), 1'b1, 1'b0, 8'($urandom));
        acc(amap[1], 1'b0, 1'b1, 8'h00);
        acc(amap[3], 1'b0, 1'b1, 8'h00);
        idle();
        for (int k = 0; k < 10 && exp_q.size() != 0; k++) idle();
        if (exp_q.size() != 0) fail("acks missing");
        report_and_stop();
    end
endmodule
